// ---- verif/fault_latch_and_serial_control_tb_top.sv ----
// Purpose: self-checking bench of fault latching and serial access
// Assumes: detector levels show at outputs within 6 core cycles
// Notes: writes land a few core cycles after chip select rises
`timescale 1ns/1ps
module fault_latch_and_serial_control_tb_top;
	import fault_spi_pkg::*;
	logic                core_clk, rst_n, serialClk, chipSelect_n, serialIn, serialOut, serialOutOe_n;
	logic                uv, ov, ovExt, tw, ts, alertOut_n, alertOe_n;
	logic [HB_COUNT-1:0] hsOc, lsOc, hsOl, lsOl, lsLc, hsReq, lsReq, hsOn, lsOn;
	logic [15:0]         rx;
	logic [7:0]          stat [3] = '{8'h05, 8'h03, 8'h41};
	int                  errCount, testsRun;

	spi_host_model host (.serialClk(serialClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
		.serialOut(serialOut));
	fault_latch_and_serial_control dut (.core_clk(core_clk), .rst_n(rst_n), .serialClk(serialClk),
		.chipSelect_n(chipSelect_n), .serialIn(serialIn), .serialOut(serialOut), .serialOutOe_n(serialOutOe_n),
		.supplyUnderVolt(uv), .supplyOverVolt(ov), .supplyOverVoltExt(ovExt), .thermalWarn(tw),
		.thermalShut(ts), .highSideOverCur(hsOc), .lowSideOverCur(lsOc), .highSideOpenLoad(hsOl),
		.lowSideOpenLoad(lsOl), .lowSideLowCurOpen(lsLc), .highSideReq(hsReq), .lowSideReq(lsReq),
		.highSideOn(hsOn), .lowSideOn(lsOn), .faultAlertOut_n(alertOut_n), .faultAlertOe_n(alertOe_n));

	// core clock
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			errCount++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic waitClk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.xfer({2'b00, a, d}, 16, rx);
		waitClk(8);
	endtask
	task automatic rd(input logic [5:0] a);
		host.xfer({2'b01, a, 8'h00}, 16, rx);
		waitClk(8);
	endtask
	task automatic reportAndStop();
		$display("checks=%0d errors=%0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog
	initial
	begin
		#200000;
		errCount++;
		reportAndStop();
	end

	// main sequence
	initial
	begin
		{rst_n, uv, ov, ovExt, tw, ts} = '0;
		{hsOc, lsOc, hsOl, lsOl, lsLc, hsReq, lsReq} = '0;
		waitClk(6);
		rst_n <= 1'b1;
		hsReq <= 6'h3F;
		waitClk(4);
		check(16'({hsOn, alertOe_n, serialOutOe_n}), 16'h00FF);
		check(16'(alertOut_n), 16'h0000);
		rd(ADDR_STATUS);
		check(rx, 16'h0000);
		wr(ADDR_CONFIG, 8'h01);
		rd(ADDR_STATUS);
		check(rx, 16'h0101);
		host.xfer({2'b00, ADDR_CONFIG, 8'h04}, 15, rx);
		waitClk(8);
		rd(ADDR_CONFIG);
		check(rx, 16'h0100);
		// supply and thermal shutdown faults, one at a time
		for (int k = 0; k < 3; k++)
		begin
			@(posedge core_clk) {ts, ov, uv} <= 3'b001 << k;
			waitClk(6);
			check(16'({hsOn, alertOe_n}), 16'h0000);
			@(posedge core_clk) {ts, ov, uv} <= 3'b000;
			waitClk(6);
			check(16'({hsOn, alertOe_n}), 16'h007F);
			rd(ADDR_STATUS);
			check(16'(rx[15:8]), 16'(stat[k]));
			wr(ADDR_CONFIG, 8'h01);
			rd(ADDR_STATUS);
			check(16'(rx[15:8]), 16'h0001);
		end
		// warning reported, outputs stay on
		wr(ADDR_CONFIG, 8'h04);
		check(rx, 16'h0100);
		@(posedge core_clk) tw <= 1'b1;
		waitClk(6);
		check(16'({hsOn, alertOe_n}), 16'h007E);
		@(posedge core_clk) tw <= 1'b0;
		waitClk(6);
		check(16'({hsOn, alertOe_n}), 16'h007F);
		wr(ADDR_CONFIG, 8'h05);
		// persistent overcurrent on bridge one high side
		@(posedge core_clk) hsOc <= 6'h01;
		waitClk(410);
		check(16'({hsOn, alertOe_n}), 16'h007C);
		@(posedge core_clk) hsOc <= 6'h00;
		rd(ADDR_OC_A);
		check(rx, 16'h0902);
		wr(ADDR_CONFIG, 8'h08);
		check(16'({hsOn, alertOe_n}), 16'h007D);
		wr(ADDR_CONFIG, 8'h01);
		check(16'({hsOn, alertOe_n}), 16'h007F);
		// deglitched open load on bridge two low side idles the bridge
		@(posedge core_clk) lsReq <= 6'h3F;
		lsOl <= 6'h02;
		waitClk(2010);
		check(16'({hsOn, lsOn, alertOe_n}), 16'h1EFA);
		rd(ADDR_OL_A);
		check(rx, 16'h1104);
		// not reported and outputs keep their state
		wr(ADDR_OLCTRL_B, 8'hC0);
		check(16'({hsOn, lsOn, alertOe_n}), 16'h1FFF);
		@(posedge core_clk) lsOl <= 6'h00;
		wr(ADDR_OLCTRL_B, 8'h00);
		wr(ADDR_CONFIG, 8'h01);
		check(16'({hsOn, lsOn, alertOe_n}), 16'h1FFF);
		// disabled bridge detects nothing
		wr(ADDR_OLCTRL_A, 8'h04);
		@(posedge core_clk) lsOl <= 6'h02;
		waitClk(2010);
		rd(ADDR_OL_A);
		check(rx, 16'h0100);
		// low-current mode: low side flag only, high side ignored
		@(posedge core_clk) lsOl <= 6'h00;
		wr(ADDR_LOWCUR, 8'h04);
		wr(ADDR_OLCTRL_A, 8'h00);
		@(posedge core_clk) hsOl <= 6'h02;
		lsLc <= 6'h02;
		waitClk(2010);
		rd(ADDR_OL_A);
		check(rx, 16'h1104);
		@(posedge core_clk) hsOl <= 6'h00;
		lsLc <= 6'h00;
		wr(ADDR_LOWCUR, 8'h00);
		wr(ADDR_CONFIG, 8'h01);
		check(16'({hsOn, lsOn, alertOe_n}), 16'h1FFF);
		// extended range ignores the normal comparator
		wr(ADDR_CONFIG, 8'h02);
		@(posedge core_clk) ov <= 1'b1;
		waitClk(6);
		check(16'({hsOn, alertOe_n}), 16'h007F);
		@(posedge core_clk) ovExt <= 1'b1;
		waitClk(6);
		check(16'({hsOn, alertOe_n}), 16'h0000);
		// mid-run logic reset: outputs off, power flag low again
		@(posedge core_clk) {ov, ovExt} <= 2'b00;
		rst_n <= 1'b0;
		waitClk(2);
		check(16'({hsOn, lsOn, alertOe_n}), 16'h0001);
		rst_n <= 1'b1;
		waitClk(4);
		rd(ADDR_STATUS);
		check(rx, 16'h0000);
		reportAndStop();
	end
endmodule

// ---- verif/spi_host_model.sv ----
// Purpose: host model, serial bus master of the link
// Assumes: link clock of 6 ns, still between frames
// Notes: idle data line shows the inverse of its last bit
`timescale 1ns/1ps
module spi_host_model (
	output logic      serialClk,
	output logic      chipSelect_n,
	output logic      serialIn,
	input  wire logic serialOut
);
	// idle levels
	initial
	begin
		serialClk = 1'b0;
		chipSelect_n = 1'b1;
		serialIn = 1'b0;
	end
	// host sends nbits clocks, 16 in a good frame
	// launch on rise, sample on fall, msb first
	task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		chipSelect_n = 1'b0;
		serialIn = w[15];
		#21;
		for (int i = 15; i > 15 - nbits; i--)
		begin
			serialClk = 1'b1;
			serialIn = w[i];
			#3;
			serialClk = 1'b0;
			rx = {rx[14:0], serialOut};
			#3;
		end
		#6;
		chipSelect_n = 1'b1;
		serialIn = ~serialIn;
		#36;
	endtask
endmodule

// ---- verilog/fault_latch_and_serial_control.sv ----
// Purpose: fault latching, output gating, fault pin and serial register access
// Assumes: detector inputs are asynchronous levels, drive requests come from core-clock logic
// Notes: the serial link runs on its own clock; chip select must lead the first clock edge
`timescale 1ns/1ps
// Notes on behaviour
// - undervoltage: outputs off, flag latched, pin low
// - undervoltage gone: outputs back, pin released
// - overvoltage: outputs off, flag, pin, recovery
// - extended bit selects extended overvoltage comparator
// - logic reset clears everything, outputs off
// - power flag low after reset until clear
// - persistent overcurrent latches switch off, flags
// - overcurrent mask keeps pin released
// - deglitched open load registers, pulls pin low
// - open load sets summary and switch flags
// - per-bridge open load disable, enabled at reset
// - open load report select gates pin
// - response zero puts bridge high impedance
// - low-current mode: low side only, hides high
// - thermal warning latched, outputs stay active
// - warning report pulls pin while warning active
// - thermal shutdown: outputs off, flag, recovery
// - deselected link ignored, output released
// - sample falling, launch rising, msb first
// - exactly sixteen clocks make a frame
// - frame: zero, read bit, address, data
// - status byte shifted out during address
// - write shifts out old register contents
// - status byte bit layout, bit seven zero
module fault_latch_and_serial_control (
	input  wire logic                               core_clk,
	input  wire logic                               rst_n,
	input  wire logic                               serialClk,
	input  wire logic                               chipSelect_n,
	input  wire logic                               serialIn,
	output logic                                    serialOut,
	output logic                                    serialOutOe_n,
	input  wire logic                               supplyUnderVolt,
	input  wire logic                               supplyOverVolt,
	input  wire logic                               supplyOverVoltExt,
	input  wire logic                               thermalWarn,
	input  wire logic                               thermalShut,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] highSideOverCur,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] lowSideOverCur,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] highSideOpenLoad,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] lowSideOpenLoad,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] lowSideLowCurOpen,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] highSideReq,
	input  wire logic [fault_spi_pkg::HB_COUNT-1:0] lowSideReq,
	output logic [fault_spi_pkg::HB_COUNT-1:0]      highSideOn,
	output logic [fault_spi_pkg::HB_COUNT-1:0]      lowSideOn,
	output logic                                    faultAlertOut_n,
	output logic                                    faultAlertOe_n
);
	import fault_spi_pkg::*;

	localparam int RAW_W = 5 + 5 * HB_COUNT;

	spi_frame_if frameIf ();

	logic [RAW_W-1:0]    syncA_q;
	logic [RAW_W-1:0]    syncB_q;
	logic [1:0]          csSync_q;
	logic                csPrev_q;
	logic [2:0]          doneSync_q;
	logic [2:0]          extraSync_q;
	logic                pending_q;
	logic                uvS;
	logic                ovS;
	logic                ovExtS;
	logic                twS;
	logic                tsS;
	logic [SW_COUNT-1:0] ocS;
	logic [SW_COUNT-1:0] olRawS;
	logic [SW_COUNT-1:0] olS;
	logic [SW_COUNT-1:0] swReq;
	logic [SW_COUNT-1:0] ocHit;
	logic [SW_COUNT-1:0] olHit;
	logic                csS;
	logic                csRise;
	logic                doneEdge;
	logic                extraEdge;
	logic                commit;
	logic                cmdWrite;
	logic [5:0]          cmdAddr;
	logic [7:0]          cmdData;
	logic                ovActive;
	logic                globalOff;
	logic                faultActive;
	logic [SW_COUNT-1:0] swBlock;
	logic [7:0]          statusByte;
	reg_bank_type        liveBank;
	// configuration and flags
	logic                extOv_q;
	logic                twRep_q;
	logic                ocMask_q;
	logic [HB_COUNT-1:0] olDis_q;
	logic                olRep_q;
	logic                olResp_q;
	logic [HB_COUNT-1:0] lowCur_q;
	logic                clrPulse_q;
	logic                uvFlag_q;
	logic                ovFlag_q;
	logic                nporFlag_q;
	logic                twFlag_q;
	logic                tsFlag_q;
	logic [SW_COUNT-1:0] ocFlag_q;
	logic [SW_COUNT-1:0] olFlag_q;
	logic [SW_COUNT-1:0] swOn_q;
	logic                alertOe_n_q;

	spi_link link (
		.rst_n         (rst_n),
		.serialClk     (serialClk),
		.chipSelect_n  (chipSelect_n),
		.serialIn      (serialIn),
		.serialOut     (serialOut),
		.serialOutOe_n (serialOutOe_n),
		.frame         (frameIf.link)
	);

	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			syncA_q     <= '0;
			syncB_q     <= '0;
			csSync_q    <= 2'h3;
			csPrev_q    <= 1'b1;
			doneSync_q  <= 3'h0;
			extraSync_q <= 3'h0;
		end
		else
		begin
			syncA_q     <= {supplyUnderVolt, supplyOverVolt, supplyOverVoltExt, thermalWarn, thermalShut,
			                highSideOverCur, lowSideOverCur, highSideOpenLoad, lowSideOpenLoad, lowSideLowCurOpen};
			syncB_q     <= syncA_q;
			csSync_q    <= {csSync_q[0], chipSelect_n};
			csPrev_q    <= csSync_q[1];
			doneSync_q  <= {doneSync_q[1:0], frameIf.doneTgl};
			extraSync_q <= {extraSync_q[1:0], frameIf.extraTgl};
		end

	// unpack synchronised detector levels
	assign uvS    = syncB_q[RAW_W-1];
	assign ovS    = syncB_q[RAW_W-2];
	assign ovExtS = syncB_q[RAW_W-3];
	assign twS    = syncB_q[RAW_W-4];
	assign tsS    = syncB_q[RAW_W-5];
	assign ocS    = interleave(syncB_q[5*HB_COUNT-1:4*HB_COUNT], syncB_q[4*HB_COUNT-1:3*HB_COUNT]);
	assign olRawS = interleave(syncB_q[3*HB_COUNT-1:2*HB_COUNT], syncB_q[2*HB_COUNT-1:HB_COUNT]);
	assign swReq  = interleave(highSideReq, lowSideReq);

	// frame events seen in the core domain
	assign csS       = csSync_q[1];
	assign csRise    = csS & ~csPrev_q;
	assign doneEdge  = doneSync_q[2] ^ doneSync_q[1];
	assign extraEdge = extraSync_q[2] ^ extraSync_q[1];
	// commit only a frame without extra clocks
	assign commit    = csRise & pending_q & ~extraEdge;
	// top bit zero and write bit zero
	assign cmdWrite  = commit & ~frameIf.frameWord[FR_ZERO_BIT] & ~frameIf.frameWord[FR_RW_BIT];
	assign cmdAddr   = frameIf.frameWord[13:8];
	assign cmdData   = frameIf.frameWord[7:0];

	// frame pending between sixteenth clock and deselect
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			pending_q <= 1'b0;
		else
			pending_q <= (pending_q | doneEdge) & ~extraEdge & ~csRise;

	// writable configuration, address chain
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			extOv_q  <= 1'b0;
			twRep_q  <= 1'b0;
			ocMask_q <= 1'b0;
			olDis_q  <= RST_HB; // detection enabled
			olRep_q  <= 1'b0;
			olResp_q <= 1'b0;
			lowCur_q <= RST_HB;
		end
		else if (cmdWrite)
		begin
			if (cmdAddr == ADDR_CONFIG)
			begin
				extOv_q  <= cmdData[CFG_EXTOV_BIT];
				twRep_q  <= cmdData[CFG_TWREP_BIT];
				ocMask_q <= cmdData[CFG_OCMSK_BIT];
			end
			else if (cmdAddr == ADDR_OLCTRL_A)
				olDis_q <= cmdData[HB_COUNT:1];
			else if (cmdAddr == ADDR_OLCTRL_B)
			begin
				olRep_q  <= cmdData[OLB_REP_BIT];
				olResp_q <= cmdData[OLB_RESP_BIT];
			end
			else if (cmdAddr == ADDR_LOWCUR)
				lowCur_q <= cmdData[HB_COUNT:1];
		end

	// clear bit acts once and is not stored
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			clrPulse_q <= 1'b0;
		else
			clrPulse_q <= cmdWrite && cmdAddr == ADDR_CONFIG && cmdData[CFG_CLEAR_BIT];

	// per-switch persistence timers
	for (genvar j = 0; j < SW_COUNT; j++)
	begin : gSw
		logic [CNT_W-1:0] ocCnt_q;
		logic [CNT_W-1:0] olCnt_q;
		// low-current mode widens low side, hides high side
		if (j % 2 == 0)
		begin : gLow
			assign olS[j] = ~olDis_q[j/2] & (olRawS[j] | (lowCur_q[j/2] & syncB_q[j/2]));
		end
		else
		begin : gHigh
			assign olS[j] = ~olDis_q[j/2] & ~lowCur_q[j/2] & olRawS[j];
		end
		always_ff @(posedge core_clk or negedge rst_n)
			if (!rst_n)
				ocCnt_q <= '0;
			else if (!ocS[j])
				ocCnt_q <= '0;
			else if (ocCnt_q != OC_CYCLES)
				ocCnt_q <= ocCnt_q + 12'h001;
		always_ff @(posedge core_clk or negedge rst_n)
			if (!rst_n)
				olCnt_q <= '0;
			else if (!olS[j])
				olCnt_q <= '0;
			else if (olCnt_q != OL_CYCLES)
				olCnt_q <= olCnt_q + 12'h001;
		assign ocHit[j] = ocCnt_q == OC_CYCLES;
		assign olHit[j] = olCnt_q == OL_CYCLES;
	end

	assign ovActive = extOv_q ? ovExtS : ovS;

	// supply flags, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			uvFlag_q <= 1'b0;
			ovFlag_q <= 1'b0;
		end
		else
		begin
			uvFlag_q <= uvS | (uvFlag_q & ~clrPulse_q);
			ovFlag_q <= ovActive | (ovFlag_q & ~clrPulse_q);
		end

	// power flag low from reset until a clear
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			nporFlag_q <= 1'b0;
		else if (clrPulse_q)
			nporFlag_q <= 1'b1;

	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			twFlag_q <= 1'b0;
			tsFlag_q <= 1'b0;
		end
		else
		begin
			twFlag_q <= twS | (twFlag_q & ~(clrPulse_q & ~twS));
			tsFlag_q <= tsS | (tsFlag_q & ~(clrPulse_q & ~tsS));
		end

	// switch flags, cleared only if cause gone
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			ocFlag_q <= '0;
			olFlag_q <= '0;
		end
		else
		begin
			ocFlag_q <= ocHit | (ocFlag_q & ~({SW_COUNT{clrPulse_q}} & ~ocS));
			olFlag_q <= olHit | (olFlag_q & ~({SW_COUNT{clrPulse_q}} & ~olS));
		end

	assign globalOff = uvS | ovActive | tsS;
	// open load with response zero idles both switches of the bridge
	for (genvar h = 0; h < HB_COUNT; h++)
	begin : gBlock
		assign swBlock[2*h]   = ocFlag_q[2*h] | (~olResp_q & |olFlag_q[2*h+1:2*h]);
		assign swBlock[2*h+1] = ocFlag_q[2*h+1] | (~olResp_q & |olFlag_q[2*h+1:2*h]);
	end

	// output stage drive
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			swOn_q <= '0;
		else
			swOn_q <= swReq & ~swBlock & {SW_COUNT{~globalOff}};

	assign faultActive = globalOff | (twRep_q & twS) | (~ocMask_q & |ocFlag_q) | (~olRep_q & |olFlag_q);
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			alertOe_n_q <= 1'b1;
		else
			alertOe_n_q <= ~faultActive;

	// pin and output mapping
	assign faultAlertOut_n = 1'b0;
	assign faultAlertOe_n  = alertOe_n_q;
	for (genvar h = 0; h < HB_COUNT; h++)
	begin : gOut
		assign lowSideOn[h]  = swOn_q[2*h];
		assign highSideOn[h] = swOn_q[2*h+1];
	end

	assign statusByte = {1'b0, tsFlag_q, twFlag_q, |olFlag_q, |ocFlag_q, uvFlag_q, ovFlag_q, nporFlag_q};
	assign liveBank = {
		{1'b0, lowCur_q, 1'b0},
		{olRep_q, olResp_q, 6'h00},
		{1'b0, olDis_q, 1'b0},
		{4'h0, ocMask_q, twRep_q, extOv_q, 1'b0},
		{4'h0, olFlag_q[SW_COUNT-1:8]},
		olFlag_q[7:0],
		{4'h0, ocFlag_q[SW_COUNT-1:8]},
		ocFlag_q[7:0],
		statusByte
	};

	// bank frozen while a frame is open
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			frameIf.snapBank <= '0;
		else if (csS)
			frameIf.snapBank <= liveBank;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	uvOff_a: assert property (uvS |=> swOn_q == '0 && !alertOe_n_q && uvFlag_q)
		else $error("undervoltage did not stop outputs");
	uvHold_a: assert property (uvFlag_q && !clrPulse_q |=> uvFlag_q)
		else $error("undervoltage flag lost without clear");
	ovLatch_a: assert property (ovS && !extOv_q |=> ovFlag_q && swOn_q == '0)
		else $error("overvoltage not latched");
	extOv_a: assert property (extOv_q && ovS && !ovExtS && !uvS && !tsS |=> swOn_q == $past(swReq & ~swBlock))
		else $error("normal threshold used in extended mode");
	nporSet_a: assert property (clrPulse_q |=> nporFlag_q)
		else $error("power flag not restored by clear");
	ocOff_a: assert property (ocFlag_q[0] |=> !swOn_q[0])
		else $error("overcurrent switch still driven");
	ocMask_a: assert property (ocMask_q && !globalOff && !twS && olFlag_q == '0 |=> alertOe_n_q)
		else $error("masked overcurrent pulled pin");
	olPin_a: assert property ($rose(olFlag_q[1]) && !olRep_q |=> !alertOe_n_q)
		else $error("open load did not pull pin");
	olHiz_a: assert property (olFlag_q[1] && !olResp_q |=> !swOn_q[0] && !swOn_q[1])
		else $error("bridge driven after open load");
	warnKeep_a: assert property (twS && !globalOff && ocFlag_q == '0 && olFlag_q == '0 |=> swOn_q == $past(swReq))
		else $error("warning changed outputs");
	tsdOff_a: assert property (tsS |=> tsFlag_q && swOn_q == '0)
		else $error("shutdown did not stop outputs");
	extraDrop_a: assert property (extraEdge |=> !pending_q)
		else $error("overlong frame still pending");
	clrKeep_a: assert property (clrPulse_q && ocS[0] && ocFlag_q[0] |=> ocFlag_q[0])
		else $error("active overcurrent flag cleared");

	frameWrite_c: cover property (cmdWrite && cmdAddr == ADDR_CONFIG);
	clearAll_c: cover property (clrPulse_q ##1 nporFlag_q);
	olLatch_c: cover property ($rose(olFlag_q[0]));
	overlong_c: cover property (extraEdge && pending_q);
endmodule

// ---- verilog/fault_spi_pkg.sv ----
// Purpose: shared constants, types and helpers of the fault latch and serial control block
// Assumes: 200 MHz core clock, six half-bridges, 16-bit serial frame
// Notes: switch vectors interleave low side at even and high side at odd positions
package fault_spi_pkg;
	localparam int HB_COUNT   = 6;
	localparam int SW_COUNT   = 2 * HB_COUNT;
	localparam int FRAME_BITS = 16;
	localparam int NUM_REGS   = 9;
	localparam int CNT_W      = 12;
	localparam int CLK_MHZ    = 200;
	// persistence times, in ns
	localparam int OC_SHUTDOWN_NS = 2000;
	localparam int OL_DEGLITCH_NS = 10000;
	localparam logic [CNT_W-1:0] OC_CYCLES = CNT_W'((OC_SHUTDOWN_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] OL_CYCLES = CNT_W'((OL_DEGLITCH_NS * CLK_MHZ + 999) / 1000);
	// bit counter values in the link
	localparam logic [4:0] LAST_BIT    = 5'h0F;
	localparam logic [4:0] EXTRA_COUNT = 5'h10;
	localparam logic [4:0] ADDR_DONE   = 5'h08;
	localparam logic [4:0] TOP_COUNT   = 5'h11;
	// frame fields
	localparam int FR_ZERO_BIT = 15;
	localparam int FR_RW_BIT   = 14;
	// register addresses
	localparam logic [5:0] ADDR_STATUS   = 6'h00;
	localparam logic [5:0] ADDR_OC_A     = 6'h01;
	localparam logic [5:0] ADDR_OC_B     = 6'h02;
	localparam logic [5:0] ADDR_OL_A     = 6'h04;
	localparam logic [5:0] ADDR_OL_B     = 6'h05;
	localparam logic [5:0] ADDR_CONFIG   = 6'h07;
	localparam logic [5:0] ADDR_OLCTRL_A = 6'h1F;
	localparam logic [5:0] ADDR_OLCTRL_B = 6'h20;
	localparam logic [5:0] ADDR_LOWCUR   = 6'h22;
	// configuration field positions
	localparam int CFG_CLEAR_BIT = 0;
	localparam int CFG_EXTOV_BIT = 1;
	localparam int CFG_TWREP_BIT = 2;
	localparam int CFG_OCMSK_BIT = 3;
	localparam int OLB_RESP_BIT  = 6;
	localparam int OLB_REP_BIT   = 7;
	// bank positions
	localparam logic [3:0] IDX_STATUS = 4'h0;
	localparam logic [3:0] IDX_NONE   = 4'hF;
	// reset values
	localparam logic [7:0]          RST_BYTE = 8'h00;
	localparam logic [HB_COUNT-1:0] RST_HB   = 6'h00;
	typedef logic [NUM_REGS-1:0][7:0] reg_bank_type;

	// bank position of a readable address
	function automatic logic [3:0] regIndex(input logic [5:0] addr);
		if (addr == ADDR_STATUS) regIndex = 4'h0;
		else if (addr == ADDR_OC_A) regIndex = 4'h1;
		else if (addr == ADDR_OC_B) regIndex = 4'h2;
		else if (addr == ADDR_OL_A) regIndex = 4'h3;
		else if (addr == ADDR_OL_B) regIndex = 4'h4;
		else if (addr == ADDR_CONFIG) regIndex = 4'h5;
		else if (addr == ADDR_OLCTRL_A) regIndex = 4'h6;
		else if (addr == ADDR_OLCTRL_B) regIndex = 4'h7;
		else if (addr == ADDR_LOWCUR) regIndex = 4'h8;
		else regIndex = IDX_NONE;
	endfunction

	// merge per-bridge high and low side bits into switch order
	function automatic logic [SW_COUNT-1:0] interleave(input logic [HB_COUNT-1:0] hs, input logic [HB_COUNT-1:0] ls);
		interleave = '0;
		for (int i = 0; i < HB_COUNT; i++)
		begin
			interleave[2*i]   = ls[i];
			interleave[2*i+1] = hs[i];
		end
	endfunction
endpackage

// ---- verilog/spi_frame_if.sv ----
// Purpose: carrier between the serial link domain and the core domain
// Assumes: toggles cross by two-flop sync; the word is stable when its toggle is seen
// Notes: the bank is frozen by the core while a frame is open
`timescale 1ns/1ps
interface spi_frame_if;
	logic [15:0]                 frameWord;
	logic                        doneTgl;
	logic                        extraTgl;
	fault_spi_pkg::reg_bank_type snapBank;
	modport link (output frameWord, output doneTgl, output extraTgl, input snapBank);
	modport core (input frameWord, input doneTgl, input extraTgl, output snapBank);
endinterface

// ---- verilog/spi_link.sv ----
// Purpose: serial shift logic on the host serial clock
// Assumes: chip select high clears the bit counter and output shifter
// Notes: data sampled on falling edge, launched on rising edge, msb first
`timescale 1ns/1ps
module spi_link (
	input  wire logic  rst_n,
	input  wire logic  serialClk,
	input  wire logic  chipSelect_n,
	input  wire logic  serialIn,
	output logic       serialOut,
	output logic       serialOutOe_n,
	spi_frame_if.link  frame
);
	import fault_spi_pkg::*;

	logic [4:0]  bitCnt_q;
	logic [15:0] rxShift_q;
	logic [7:0]  txByte_q;
	logic [7:0]  rdByte;
	logic [3:0]  rdIdx;
	logic        frameRst_n;

	// frame state lives only while chip select is low
	assign frameRst_n = rst_n & ~chipSelect_n;
	assign serialOutOe_n = chipSelect_n;

	always_ff @(negedge serialClk or negedge frameRst_n)
		if (!frameRst_n)
		begin
			bitCnt_q  <= 5'h00;
			rxShift_q <= 16'h0000;
		end
		else
		begin
			rxShift_q <= {rxShift_q[14:0], serialIn};
			if (bitCnt_q != TOP_COUNT)
				bitCnt_q <= bitCnt_q + 5'h01;
		end

	always_ff @(negedge serialClk or negedge rst_n)
		if (!rst_n)
		begin
			frame.frameWord <= 16'h0000;
			frame.doneTgl   <= 1'b0;
			frame.extraTgl  <= 1'b0;
		end
		else if (!chipSelect_n)
		begin
			if (bitCnt_q == LAST_BIT)
			begin
				frame.frameWord <= {rxShift_q[14:0], serialIn};
				frame.doneTgl   <= ~frame.doneTgl;
			end
			if (bitCnt_q == EXTRA_COUNT)
				frame.extraTgl <= ~frame.extraTgl;
		end

	// addressed byte from the frozen bank, zero when unmapped
	assign rdIdx  = regIndex(rxShift_q[5:0]);
	assign rdByte = (rdIdx < 4'(NUM_REGS)) ? frame.snapBank[rdIdx] : RST_BYTE;

	always_ff @(posedge serialClk or negedge frameRst_n)
		if (!frameRst_n)
		begin
			serialOut <= 1'b0; // status bit 7 reads zero
			txByte_q  <= RST_BYTE;
		end
		else if (bitCnt_q >= 5'h01 && bitCnt_q < ADDR_DONE)
			serialOut <= frame.snapBank[IDX_STATUS][~bitCnt_q[2:0]];
		else if (bitCnt_q == ADDR_DONE)
		begin
			txByte_q  <= rdByte;
			serialOut <= rdByte[7];
		end
		else if (bitCnt_q > ADDR_DONE && bitCnt_q <= LAST_BIT)
			serialOut <= txByte_q[~bitCnt_q[2:0]];
endmodule
